/* File: hdl/hvi_bank.sv */
// Indirect data register, command engine and first configuration register
// Contract
// - 12-bit memory-mapped data register holds byte to write or read back.
// - Data bits 11:8 show owning command; read-only, software writes zeros.
// - Command 0x00 reads config first, 0x01 reads config second into data.
// - Command 0x02 reads status, 0x03 reads monitor into data register.
// - Command 0x08 writes data byte to config first, 0x09 to second.
// - Data bits 7:0 carry the byte for reads and writes.
// - Config first is 8 bits, resets to 0x00, reached only indirectly.
// - Config bit 7 set disables automatic thermal shutdown of driver.
// - Config bit 6 enables the precision oscillator; clear powers down.
// - Config bit 5 removes LIN pull-up, selects bit-serial mode.
// - Config bit 4 drives wake pin high; clear pulls it low.
// - Config bit 3 enables supply monitor and its low supply interrupt.
// - Config bit 2 enables the low voltage flag.
// - Config bits 1:0 select LIN mode: 00 off, 10 on; others reserved.
// - Completion bits are invalid while busy, valid after it clears.
`timescale 1ns/100ps
module hvi_bank
    import hvi_pkg::*;
#(
    parameter int LATENCY_CYC = HVI_LATENCY_CYC
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [31:0] bus_addr_i,
    input wire logic bus_wr_i,
    input wire logic [31:0] bus_wdata_i,
    output logic [31:0] bus_rdata_o,
    input wire logic [7:0] hv_config_second_i,
    input wire logic [7:0] hv_status_register_i,
    input wire logic [7:0] hv_monitor_register_i,
    output logic [7:0] hv_config_first_o,
    output logic [7:0] hv_config_second_wdata_o,
    output logic hv_config_second_we_o,
    output logic tsd_disable_o,
    output logic osc_enable_o,
    output logic bit_serial_device_mode_o,
    output logic wake_pin_o,
    output logic supply_monitor_o,
    output logic low_voltage_flag_o,
    output logic lin_enable_o
);
    logic [7:0] sec_s1_reg, sec_s2_reg, sta_s1_reg, sta_s2_reg;
    logic [7:0] mon_s1_reg, mon_s2_reg;
    logic [11:0] data_reg, data_next;
    logic [7:0] cfg0_reg, cfg0_next;
    logic [7:0] cmd_reg, cmd_next;
    logic [2:0] stat_reg, stat_next;
    logic [15:0] cnt_reg, cnt_next;
    hvi_state_t state_reg, state_next;
    logic [7:0] cfg1_wd_reg, cfg1_wd_next;
    logic cfg1_we_reg, cfg1_we_next;
    logic [31:0] rdata_reg, rdata_next;
    hvi_ctrl_t ctrl_reg, ctrl_next;
    logic [7:0] fetch;
    logic fetch_ok;

    always_ff @(posedge core_clk_i) begin
        sec_s1_reg <= hv_config_second_i;
        sec_s2_reg <= sec_s1_reg;
        sta_s1_reg <= hv_status_register_i;
        sta_s2_reg <= sta_s1_reg;
        mon_s1_reg <= hv_monitor_register_i;
        mon_s2_reg <= mon_s1_reg;
    end

    always_comb begin
        fetch_ok = 1'b1;
        unique case (cmd_reg)
            HVI_RD_CFG0: fetch = cfg0_reg;
            HVI_RD_CFG1: fetch = sec_s2_reg;
            HVI_RD_STAT: fetch = sta_s2_reg;
            HVI_RD_MON: fetch = mon_s2_reg;
            default: begin
                fetch = 8'h00;
                fetch_ok = 1'b0;
            end
        endcase
    end

    always_comb begin
        data_next = data_reg;
        cfg0_next = cfg0_reg;
        cmd_next = cmd_reg;
        stat_next = stat_reg;
        cnt_next = cnt_reg;
        state_next = state_reg;
        cfg1_wd_next = cfg1_wd_reg;
        cfg1_we_next = 1'b0;
        unique case (state_reg)
            HVI_IDLE: begin
                if (bus_wr_i && bus_addr_i == HVI_DATA_ADDR) begin
                    data_next[7:0] = bus_wdata_i[7:0];
                end
                if (bus_wr_i && bus_addr_i == HVI_CMD_ADDR) begin
                    cmd_next = bus_wdata_i[7:0];
                    cnt_next = 16'(LATENCY_CYC);
                    stat_next = 3'h1;
                    state_next = HVI_BUSY;
                end
            end
            HVI_BUSY: begin
                if (cnt_reg > 16'h0001) begin
                    cnt_next = cnt_reg - 16'h0001;
                end else begin
                    state_next = HVI_IDLE;
                    stat_next = 3'h0;
                    if (cmd_reg == HVI_WR_CFG0) begin
                        cfg0_next = data_reg[7:0];
                        stat_next = 3'h4;
                    end else if (cmd_reg == HVI_WR_CFG1) begin
                        cfg1_wd_next = data_reg[7:0];
                        cfg1_we_next = 1'b1;
                        stat_next = 3'h4;
                    end else if (fetch_ok) begin
                        data_next = {cmd_reg[3:0], fetch};
                        stat_next = 3'h2;
                    end
                end
            end
            default: state_next = HVI_IDLE;
        endcase
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (bus_addr_i == HVI_DATA_ADDR) begin
            rdata_next = {20'h00000, data_reg};
        end else if (bus_addr_i == HVI_CMD_ADDR) begin
            rdata_next = {29'h0000_0000, stat_reg};
        end
        ctrl_next.tsd_disable = cfg0_reg[HVI_TSD_DIS_BIT];
        ctrl_next.osc_enable = cfg0_reg[HVI_OSC_EN_BIT];
        ctrl_next.bsd_mode = cfg0_reg[HVI_BSD_BIT];
        ctrl_next.wake_high = cfg0_reg[HVI_WAKE_BIT];
        ctrl_next.psm_enable = cfg0_reg[HVI_PSM_BIT];
        ctrl_next.lvf_enable = cfg0_reg[HVI_LVF_BIT];
        ctrl_next.lin_enable = (cfg0_reg[1:0] == HVI_LIN_ON);
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            data_reg <= HVI_DATA_RST;
            cfg0_reg <= HVI_CFG0_RST;
            cmd_reg <= 8'h00;
            stat_reg <= 3'h0;
            cnt_reg <= 16'h0000;
            state_reg <= HVI_IDLE;
            cfg1_wd_reg <= HVI_CFG1_RST;
            cfg1_we_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            ctrl_reg <= '0;
        end else begin
            data_reg <= data_next;
            cfg0_reg <= cfg0_next;
            cmd_reg <= cmd_next;
            stat_reg <= stat_next;
            cnt_reg <= cnt_next;
            state_reg <= state_next;
            cfg1_wd_reg <= cfg1_wd_next;
            cfg1_we_reg <= cfg1_we_next;
            rdata_reg <= rdata_next;
            ctrl_reg <= ctrl_next;
        end
    end

    assign bus_rdata_o = rdata_reg;
    assign hv_config_first_o = cfg0_reg;
    assign hv_config_second_wdata_o = cfg1_wd_reg;
    assign hv_config_second_we_o = cfg1_we_reg;
    assign tsd_disable_o = ctrl_reg.tsd_disable;
    assign osc_enable_o = ctrl_reg.osc_enable;
    assign bit_serial_device_mode_o = ctrl_reg.bsd_mode;
    assign wake_pin_o = ctrl_reg.wake_high;
    assign supply_monitor_o = ctrl_reg.psm_enable;
    assign low_voltage_flag_o = ctrl_reg.lvf_enable;
    assign lin_enable_o = ctrl_reg.lin_enable;
endmodule : hvi_bank

/* File: inc/hvi_pkg.sv */
// Package for the high voltage indirect data and configuration block
package hvi_pkg;
    localparam logic [31:0] HVI_DATA_ADDR = 32'hffff080c;
    localparam logic [31:0] HVI_CMD_ADDR = 32'hffff0804;
    localparam logic [11:0] HVI_DATA_RST = 12'h000;
    localparam logic [7:0] HVI_CFG0_RST = 8'h00;
    localparam logic [7:0] HVI_CFG1_RST = 8'h00;
    localparam int HVI_CMD_LSB = 8;
    localparam int HVI_TSD_DIS_BIT = 7;
    localparam int HVI_OSC_EN_BIT = 6;
    localparam int HVI_BSD_BIT = 5;
    localparam int HVI_WAKE_BIT = 4;
    localparam int HVI_PSM_BIT = 3;
    localparam int HVI_LVF_BIT = 2;
    localparam logic [1:0] HVI_LIN_OFF = 2'h0;
    localparam logic [1:0] HVI_LIN_ON = 2'h2;
    localparam logic [7:0] HVI_RD_CFG0 = 8'h00;
    localparam logic [7:0] HVI_RD_CFG1 = 8'h01;
    localparam logic [7:0] HVI_RD_STAT = 8'h02;
    localparam logic [7:0] HVI_RD_MON = 8'h03;
    localparam logic [7:0] HVI_WR_CFG0 = 8'h08;
    localparam logic [7:0] HVI_WR_CFG1 = 8'h09;
    localparam int HVI_LATENCY_NS = 10000;
    localparam int HVI_CLK_NS = 4;
    localparam int HVI_LATENCY_CYC = HVI_LATENCY_NS / HVI_CLK_NS;

    typedef struct packed {
        logic tsd_disable;
        logic osc_enable;
        logic bsd_mode;
        logic wake_high;
        logic psm_enable;
        logic lvf_enable;
        logic lin_enable;
    } hvi_ctrl_t;

    typedef enum logic [1:0] {
        HVI_IDLE = 2'b01,
        HVI_BUSY = 2'b10
    } hvi_state_t;
endpackage : hvi_pkg

/* File: dv/hvi_die_model.sv */
// Behavioural model of the high voltage die registers
`timescale 1ns/100ps
module hvi_die_model (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic we_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] cfg_o,
    output logic [7:0] stat_o,
    output logic [7:0] mon_o
);
    assign stat_o = 8'h5c;
    assign mon_o = 8'ha3;
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            cfg_o <= 8'h00;
        end else if (we_i) begin
            cfg_o <= wdata_i;
        end
    end
endmodule : hvi_die_model

/* File: dv/hvi_bank_properties.sv */
// Assertion checker for the indirect data and config bank
`timescale 1ns/100ps
module hvi_bank_properties
    import hvi_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [31:0] bus_addr_i,
    input wire logic [31:0] bus_rdata_o,
    input wire logic [7:0] hv_config_first_o,
    input wire logic hv_config_second_we_o,
    input wire logic tsd_disable_o,
    input wire logic osc_enable_o,
    input wire logic bit_serial_device_mode_o,
    input wire logic wake_pin_o,
    input wire logic supply_monitor_o,
    input wire logic low_voltage_flag_o,
    input wire logic lin_enable_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_bits_follow: assert property ({tsd_disable_o, osc_enable_o,
        bit_serial_device_mode_o, wake_pin_o, supply_monitor_o,
        low_voltage_flag_o} == $past(hv_config_first_o[7:2]))
        else $error("config outputs wrong");
    a_lin_decode: assert property (lin_enable_o ==
        ($past(hv_config_first_o[1:0]) == HVI_LIN_ON)) else $error("lin wrong");
    a_reset_clear: assert property ($fell(sys_rst_i) |->
        hv_config_first_o == 8'h00 && !lin_enable_o) else $error("reset");
    a_data_upper: assert property ($past(bus_addr_i) == HVI_DATA_ADDR |->
        bus_rdata_o[31:12] == 20'h0) else $error("data width");
    a_cmd_reserved: assert property ($past(bus_addr_i) == HVI_CMD_ADDR |->
        bus_rdata_o[31:3] == 29'h0) else $error("status reserved");
    a_other_zero: assert property ($past(bus_addr_i) != HVI_DATA_ADDR &&
        $past(bus_addr_i) != HVI_CMD_ADDR |-> bus_rdata_o == 32'h0)
        else $error("unmapped read");
    a_pulse_single: assert property (hv_config_second_we_o |=>
        !hv_config_second_we_o) else $error("write pulse long");
    a_cfg_isolate: assert property (hv_config_second_we_o |->
        $stable(hv_config_first_o)) else $error("wrong config");
    c_second: cover property (hv_config_second_we_o);
    c_lin: cover property (lin_enable_o);
    c_wake: cover property ($rose(wake_pin_o));
endmodule : hvi_bank_properties
bind hvi_bank hvi_bank_properties u_props (.core_clk_i, .sys_rst_i,
    .bus_addr_i, .bus_rdata_o, .hv_config_first_o, .hv_config_second_we_o,
    .tsd_disable_o, .osc_enable_o, .bit_serial_device_mode_o, .wake_pin_o,
    .supply_monitor_o, .low_voltage_flag_o, .lin_enable_o);

/* File: dv/testbench.sv */
// Self-checking testbench for the indirect data and config bank
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    mismatches++; $display("CHECK FAILED at %0t: mismatch", $time); end end
module testbench;
    import hvi_pkg::*;
    logic core_clk_i, sys_rst_i, bus_wr_i, hv_config_second_we_o;
    logic [31:0] bus_addr_i, bus_wdata_i, bus_rdata_o, v;
    logic [7:0] hv_config_second_i, hv_status_register_i, hv_monitor_register_i;
    logic [7:0] hv_config_first_o, hv_config_second_wdata_o;
    logic tsd_disable_o, osc_enable_o, bit_serial_device_mode_o, wake_pin_o;
    logic supply_monitor_o, low_voltage_flag_o, lin_enable_o;
    int mismatches = 0;
    int samples_checked = 0;
    logic [7:0] tab [8] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
    hvi_bank #(.LATENCY_CYC(4)) dut (.core_clk_i, .sys_rst_i, .bus_addr_i,
        .bus_wr_i, .bus_wdata_i, .bus_rdata_o, .hv_config_second_i,
        .hv_status_register_i, .hv_monitor_register_i, .hv_config_first_o,
        .hv_config_second_wdata_o, .hv_config_second_we_o, .tsd_disable_o,
        .osc_enable_o, .bit_serial_device_mode_o, .wake_pin_o,
        .supply_monitor_o, .low_voltage_flag_o, .lin_enable_o);
    hvi_die_model model (.core_clk_i, .sys_rst_i, .we_i(hv_config_second_we_o),
        .wdata_i(hv_config_second_wdata_o), .cfg_o(hv_config_second_i),
        .stat_o(hv_status_register_i), .mon_o(hv_monitor_register_i));
    task automatic end_sim();
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        bus_addr_i <= a;
        bus_wdata_i <= d;
        bus_wr_i <= 1'b1;
        @(posedge core_clk_i);
        bus_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [31:0] a);
        @(posedge core_clk_i);
        bus_addr_i <= a;
        @(posedge core_clk_i);
        #1 v = bus_rdata_o;
    endtask : rd
    task automatic idle();
        for (int i = 0; i < 40; i++) begin
            rd(HVI_CMD_ADDR);
            if (v[0] === 1'b0) return;
        end
        mismatches++;
        end_sim();
    endtask : idle
    task automatic cmd(input logic [7:0] c);
        wr(HVI_CMD_ADDR, {24'h0, c});
        rd(HVI_CMD_ADDR);
        `CHK(v[0], 1'b1)
        idle();
    endtask : cmd
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    initial begin
        sys_rst_i = 1'b1;
        bus_wr_i = 1'b0;
        bus_addr_i = 32'h0;
        bus_wdata_i = 32'h0;
        repeat (4) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        rd(HVI_DATA_ADDR);
        `CHK(v, 32'h0)
        `CHK(hv_config_first_o, HVI_CFG0_RST)
        rd(32'hffff0800);
        `CHK(v, 32'h0)
        foreach (tab[i]) begin
            wr(HVI_DATA_ADDR, {24'h0, tab[i]});
            cmd(HVI_WR_CFG0);
            `CHK(v[2:0], 3'b100)
            `CHK(hv_config_first_o, tab[i])
            `CHK({tsd_disable_o, osc_enable_o, bit_serial_device_mode_o, wake_pin_o,
                supply_monitor_o, low_voltage_flag_o}, tab[i][7:2])
            `CHK(lin_enable_o, tab[i][1:0] == HVI_LIN_ON)
            cmd(HVI_RD_CFG0);
            `CHK(v[2:0], 3'b010)
            rd(HVI_DATA_ADDR);
            `CHK(v, {24'h0, tab[i]})
        end
        wr(HVI_DATA_ADDR, 32'h5a);
        cmd(HVI_WR_CFG1);
        `CHK(hv_config_second_i, 8'h5a)
        for (int c = 1; c < 4; c++) begin
            cmd(c[7:0]);
            rd(HVI_DATA_ADDR);
            `CHK(v[11:8], c[3:0])
            `CHK(v[7:0], c == 1 ? 8'h5a : (c == 2 ? 8'h5c : 8'ha3))
        end
        wr(HVI_DATA_ADDR, 32'hf66);
        rd(HVI_DATA_ADDR);
        `CHK(v, 32'h366)
        wr(HVI_CMD_ADDR, {24'h0, HVI_WR_CFG0});
        wr(HVI_DATA_ADDR, 32'h99);
        idle();
        `CHK(hv_config_first_o, 8'h66)
        @(posedge core_clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        rd(HVI_DATA_ADDR);
        `CHK(v, 32'h0)
        `CHK(hv_config_first_o, 8'h00)
        end_sim();
    end
endmodule : testbench
